// file: hdl/flash_seq_device.sv
// Flash sequencer: column latches, key unlock, busy timer and reset boot selection.
// Assumes the core end drives the link on clk_i; pins are asynchronous.
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module flash_seq_device #(
	parameter int PAGE_BYTES = `PAGE_BYTES,
	parameter int USER_BYTES = `USER_BYTES,
	parameter int PROG_CYCLES = `PROG_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic boot_jump_bit_i,
	input wire logic program_strobe_pin_i,
	input wire logic external_access_pin_i,
	input wire logic ale_pin_i,
	flash_link_if.device link,
	output logic prog_done_o,
	output logic [15:0] prog_page_o
);
	import flash_seq_pkg::*;
	localparam int PW = $clog2(PAGE_BYTES);
	localparam int UW = $clog2(USER_BYTES);
	logic [7:0] user_flash_array [USER_BYTES];
	logic [7:0] extra_row [PAGE_BYTES];
	logic [7:0] column_latch [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] latch_valid;
	typedef struct packed {
		dev_state_t st;
		logic [7:0] key;
		logic xrow;
		logic [15:0] page;
		logic [31:0] cnt;
		logic busy;
		logic [7:0] flash_control_reg;
		logic [15:0] pc;
		logic boot_en;
		logic [7:0] user_boot_vector_byte;
		logic in_reset;
		logic done;
	} dev_t;
	dev_t state_ff;
	dev_t nxt_state;
	logic program_strobe_pin_s;
	logic ea_s;
	logic ale_s;
	logic hw_boot;
	logic user_hit;
	logic xrow_hit;
	logic load_take;
	logic prog_end;

	// No reset on the synchronisers, so pin levels have settled when reset lifts
	pin_sync #(.INIT(1'b1)) u_program_strobe_pin (
		.clk_i(clk_i),
		.reset_i(1'b0),
		.pin_i(program_strobe_pin_i),
		.sync_o(program_strobe_pin_s)
	);
	pin_sync #(.INIT(1'b0)) u_ea (
		.clk_i(clk_i),
		.reset_i(1'b0),
		.pin_i(external_access_pin_i),
		.sync_o(ea_s)
	);
	pin_sync #(.INIT(1'b0)) u_ale (
		.clk_i(clk_i),
		.reset_i(1'b0),
		.pin_i(ale_pin_i),
		.sync_o(ale_s)
	);
	// Pins are sampled at the reset release edge, the falling edge of reset
	assign hw_boot = !program_strobe_pin_s && ea_s && ale_s;
	assign user_hit = link.addr <= `USER_TOP;
	assign xrow_hit = link.addr >= `XROW_BASE;
	// A load counts only inside a latch window and never while a page is in flight
	assign load_take = link.load_we && !state_ff.busy && (user_hit || xrow_hit);
	assign prog_end = state_ff.st == dev_prog && state_ff.cnt == 32'h0;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.done = 1'b0;
		nxt_state.in_reset = 1'b0;
		if (state_ff.in_reset) begin
			nxt_state.boot_en = boot_jump_bit_i;
			if (hw_boot) begin
				nxt_state.flash_control_reg = `FLASH_CONTROL_REG_HW;
				nxt_state.pc = `PC_BOOT;
			end else begin
				nxt_state.flash_control_reg = `FLASH_CONTROL_REG_SW;
				nxt_state.pc = boot_jump_bit_i ? `PC_USER : `PC_BOOT;
			end
		end
		case (state_ff.st)
			dev_idle: begin
				if (link.ctrl_we && link.from_boot) begin
					if (link.wdata == `KEY_USER_A || link.wdata == `KEY_XROW_A) begin
						nxt_state.key = link.wdata;
						nxt_state.st = dev_key;
					end
				end
			end
			dev_key: begin
				// A wrong second key drops to idle; it is not taken as a new first key
				if (link.ctrl_we || link.load_we) begin
					nxt_state.st = dev_idle;
					if (link.ctrl_we && link.from_boot) begin
						if (state_ff.key == `KEY_USER_A && link.wdata == `KEY_USER_B) begin
							nxt_state.xrow = 1'b0;
							nxt_state.st = dev_prog;
						end else if (state_ff.key == `KEY_XROW_A
								&& link.wdata == `KEY_XROW_B) begin
							nxt_state.xrow = 1'b1;
							nxt_state.st = dev_prog;
						end
					end
				end
				// Loading one less than the count keeps busy up for exactly that many cycles
				if (nxt_state.st == dev_prog) begin
					nxt_state.busy = 1'b1;
					nxt_state.cnt = 32'(PROG_CYCLES - 1);
				end
			end
			dev_prog: begin
				if (state_ff.cnt == 32'h0) begin
					nxt_state.busy = 1'b0;
					nxt_state.done = 1'b1;
					nxt_state.st = dev_idle;
				end else begin
					nxt_state.cnt = state_ff.cnt - 32'h1;
				end
			end
			default: nxt_state.st = dev_idle;
		endcase
		// Latch loads are ignored while busy so the page in flight stays intact
		if (load_take) begin
			nxt_state.page = link.addr & ~16'(PAGE_BYTES - 1);
		end
		if (reset_i) begin
			nxt_state = '0;
			nxt_state.st = dev_idle;
			nxt_state.user_boot_vector_byte = `SBV_DEFAULT;
			nxt_state.flash_control_reg = `FLASH_CONTROL_REG_SW;
			nxt_state.pc = `PC_USER;
			nxt_state.in_reset = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		state_ff <= nxt_state;
	end
	// Loads fill latch bytes; the end of a program empties the latch
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			latch_valid <= '0;
		end else if (prog_end) begin
			latch_valid <= '0;
		end else if (load_take) begin
			latch_valid[link.addr[PW-1:0]] <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!reset_i && load_take) begin
			column_latch[link.addr[PW-1:0]] <= link.wdata;
		end
	end

	// Only bytes loaded since the last program are copied, the rest keep old contents
	// The array write happens in one cycle at the end; the timer models the wait
	always_ff @(posedge clk_i) begin
		if (!reset_i && prog_end) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (latch_valid[i]) begin
					if (state_ff.xrow) begin
						extra_row[i] <= column_latch[i];
					end else begin
						user_flash_array[{state_ff.page[UW-1:PW], PW'(i)}] <=
							column_latch[i];
					end
				end
			end
		end
	end
	// The boot array has no write path here at all
	assign link.busy = state_ff.busy;
	assign link.flash_control_reg = state_ff.flash_control_reg;
	assign link.start_pc = state_ff.pc;
	assign link.boot_en = state_ff.boot_en;
	assign link.boot_vec = state_ff.user_boot_vector_byte;
	assign prog_done_o = state_ff.done;
	assign prog_page_o = state_ff.page;
endmodule

// file: hdl/flash_seq_map.svh
// Register offsets, key bytes, reset values and timing for the flash sequencer.
// Assumes inclusion by bare name from the modules; the package does not include it.
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OFF_CTRL 4'h0
`define OFF_ADDR 4'h1
`define OFF_DATA 4'h2
`define OFF_STAT 4'h3
`define OFF_BOOT 4'h4
`define KEY_USER_A 8'h50
`define KEY_USER_B 8'hA0
`define KEY_XROW_A 8'h52
`define KEY_XROW_B 8'hA2
`define FLASH_CONTROL_REG_HW 8'h00
`define FLASH_CONTROL_REG_SW 8'hF0
`define PC_BOOT 16'hF800
`define PC_USER 16'h0000
`define SBV_DEFAULT 8'hFC
`define USER_TOP 16'h7FFF
`define XROW_BASE 16'hFF80
`define BOOT_BASE 16'hF800
`define PAGE_BYTES 128
`define USER_BYTES 32768
`define PROG_TIME_US 100
`define CLK_MHZ 20
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define ACC_LOAD 2'h1
`define ACC_CTRL 2'h2
`endif

// file: hdl/flash_seq_pkg.sv
// Types shared by both ends of the flash sequencer link.
// Assumes flash_seq_map.svh is on the include path.
package flash_seq_pkg;
	typedef enum logic [1:0] {
		acc_none,
		acc_load,
		acc_ctrl
	} acc_kind_t;
	typedef enum {
		dev_idle,
		dev_key,
		dev_prog
	} dev_state_t;
	typedef enum {
		core_idle,
		core_ack,
		core_drive,
		core_wait
	} core_state_t;
endpackage

// file: hdl/flash_link_if.sv
// Link between the CPU core end and the flash sequencer end.
// Assumes one shared clock; the bench instantiates and wires both ends.
`timescale 1ns/100ps
interface flash_link_if;
	logic load_we;
	logic ctrl_we;
	logic from_boot;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic busy;
	logic [7:0] flash_control_reg;
	logic [15:0] start_pc;
	logic boot_en;
	logic [7:0] boot_vec;
	modport device (
		input load_we, ctrl_we, from_boot, addr, wdata,
		output busy, flash_control_reg, start_pc, boot_en, boot_vec
	);
	modport core (
		output load_we, ctrl_we, from_boot, addr, wdata,
		input busy, flash_control_reg, start_pc, boot_en, boot_vec
	);
endinterface

// file: hdl/pin_sync.sv
// Two-flop synchroniser for one asynchronous pin level.
// Assumes clk_i is the sampling clock.
`timescale 1ns/100ps
module pin_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic pin_i,
	output logic sync_o
);
	typedef struct packed {
		logic meta;
		logic sync;
	} sync_state_t;
	sync_state_t state_ff;
	sync_state_t nxt_state;
	always_comb begin
		nxt_state.meta = pin_i;
		nxt_state.sync = state_ff.meta;
		if (reset_i) begin
			nxt_state.meta = INIT;
			nxt_state.sync = INIT;
		end
	end
	always_ff @(posedge clk_i) begin
		state_ff <= nxt_state;
	end
	assign sync_o = state_ff.sync;
endmodule

// file: hdl/flash_seq_core.sv
// CPU core end: classic Wishbone slave turning register writes into flash link strobes.
// Assumes the device end shares clk_i.
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module flash_seq_core (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [7:0] dat_i,
	input wire logic sel_i,
	output logic [7:0] dat_o,
	output logic ack_o,
	flash_link_if.core link
);
	import flash_seq_pkg::*;
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
		logic [15:0] addr;
		logic from_boot;
		logic load_we;
		logic ctrl_we;
		logic [7:0] wdata;
	} core_t;
	core_t state_ff;
	core_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = 1'b0;
		nxt_state.load_we = 1'b0;
		nxt_state.ctrl_we = 1'b0;
		if (cyc_i && stb_i && !state_ff.ack) begin
			nxt_state.ack = 1'b1;
			nxt_state.rdata = 8'h00;
			if (we_i && sel_i) begin
				case (adr_i)
					`OFF_CTRL: begin
						nxt_state.ctrl_we = 1'b1;
						nxt_state.wdata = dat_i;
					end
					`OFF_ADDR: nxt_state.addr = {state_ff.addr[7:0], dat_i};
					`OFF_DATA: begin
						nxt_state.load_we = 1'b1;
						nxt_state.wdata = dat_i;
					end
					`OFF_BOOT: nxt_state.from_boot = dat_i[0];
					default: ;
				endcase
			end else if (!we_i) begin
				case (adr_i)
					`OFF_CTRL: nxt_state.rdata = link.flash_control_reg;
					`OFF_ADDR: nxt_state.rdata = link.start_pc[15:8];
					`OFF_STAT: nxt_state.rdata = {6'h00, link.boot_en, link.busy};
					`OFF_BOOT: nxt_state.rdata = link.boot_vec;
					default: nxt_state.rdata = 8'h00;
				endcase
			end
		end
		if (reset_i)
			nxt_state = '0;
	end
	always_ff @(posedge clk_i) begin
		state_ff <= nxt_state;
	end
	assign ack_o = state_ff.ack;
	assign dat_o = state_ff.rdata;
	assign link.load_we = state_ff.load_we;
	assign link.ctrl_we = state_ff.ctrl_we;
	assign link.from_boot = state_ff.from_boot;
	assign link.addr = state_ff.addr;
	assign link.wdata = state_ff.wdata;
endmodule

// file: bench/flash_link_props.sv
// Concurrent checks on the flash link between the core and sequencer ends.
// Assumes one clock and the link signals wired in by name from the bench.
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module flash_link_props #(
	parameter int PROG_CYCLES = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic load_we,
	input wire logic ctrl_we,
	input wire logic from_boot,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic busy,
	input wire logic [7:0] flash_control_reg,
	input wire logic [15:0] start_pc,
	input wire logic boot_en,
	input wire logic [7:0] boot_vec
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic arm_u_ff;
	logic arm_x_ff;
	int run_ff;
	wire key_ok = ctrl_we && from_boot && !busy;
	// Any strobe between the keys disarms, so only back-to-back key writes count
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			arm_u_ff <= 1'h0;
			arm_x_ff <= 1'h0;
		end else if (ctrl_we || load_we) begin
			arm_u_ff <= key_ok && wdata == `KEY_USER_A && !arm_u_ff && !arm_x_ff;
			arm_x_ff <= key_ok && wdata == `KEY_XROW_A && !arm_u_ff && !arm_x_ff;
		end
	end
	always_ff @(posedge clk_i) begin
		run_ff <= (busy && !reset_i) ? run_ff + 1 : 0;
	end
	chk_user_start: assert property (key_ok && arm_u_ff && wdata == `KEY_USER_B |=> busy)
		else $error("user key pair did not start programming");
	chk_xrow_start: assert property (key_ok && arm_x_ff && wdata == `KEY_XROW_B |=> busy)
		else $error("extra row key pair did not start programming");
	chk_start_cause: assert property ($rose(busy) |-> $past(key_ok) &&
		($past(arm_u_ff) && $past(wdata) == `KEY_USER_B ||
		$past(arm_x_ff) && $past(wdata) == `KEY_XROW_B))
		else $error("programming started without a key pair");
	chk_busy_length: assert property ($fell(busy) |-> run_ff == PROG_CYCLES)
		else $error("busy length wrong");
	chk_busy_bound: assert property (busy |-> run_ff < PROG_CYCLES)
		else $error("busy held too long");
	chk_vec_default: assert property (boot_vec == `SBV_DEFAULT)
		else $error("boot vector not default");
	chk_boot_init: assert property ($fell(reset_i) |=>
		(flash_control_reg == `FLASH_CONTROL_REG_HW && start_pc == `PC_BOOT) || flash_control_reg == `FLASH_CONTROL_REG_SW)
		else $error("bad control value after reset");
	chk_jump_pick: assert property ($fell(reset_i) ##1 flash_control_reg == `FLASH_CONTROL_REG_SW |->
		start_pc == (boot_en ? `PC_USER : `PC_BOOT))
		else $error("start address does not follow jump bit");
	cover property (key_ok && arm_u_ff && wdata == `KEY_USER_B);
	cover property (key_ok && arm_x_ff && wdata == `KEY_XROW_B);
	cover property ($fell(reset_i) ##1 flash_control_reg == `FLASH_CONTROL_REG_HW);
endmodule

// file: bench/flash_program_boot_select_tb.sv
// Bench for the flash sequencer: Wishbone into the core end, link into the device end.
// Assumes both design ends, the link interface and the checker are compiled first.
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module flash_program_boot_select_tb;
	logic clk_i = 1'h0;
	logic reset_i = 1'h1;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, jmp = 1'h1, psn = 1'h1, acc = 1'h1, ale = 1'h1;
	logic sel = 1'h0;
	logic [3:0] adr = 4'h0;
	logic [7:0] dat = 8'h00, dat_o, rd;
	logic ack_o, done;
	logic [15:0] page;
	int fail_count = 0, cmp_count = 0, cycles = 0;
	flash_link_if lk();
	flash_seq_device #(.PROG_CYCLES(8)) u_flash_seq_device(.clk_i(clk_i), .reset_i(reset_i),
		.boot_jump_bit_i(jmp), .program_strobe_pin_i(psn), .external_access_pin_i(acc),
		.ale_pin_i(ale), .link(lk.device), .prog_done_o(done), .prog_page_o(page));
	flash_seq_core u_flash_seq_core(.clk_i(clk_i), .reset_i(reset_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel), .dat_o(dat_o), .ack_o(ack_o),
		.link(lk.core));
	flash_link_props #(.PROG_CYCLES(8)) u_flash_link_props(.clk_i(clk_i), .reset_i(reset_i),
		.load_we(lk.load_we), .ctrl_we(lk.ctrl_we), .from_boot(lk.from_boot), .addr(lk.addr),
		.wdata(lk.wdata), .busy(lk.busy), .flash_control_reg(lk.flash_control_reg), .start_pc(lk.start_pc),
		.boot_en(lk.boot_en), .boot_vec(lk.boot_vec));
	always #25 clk_i = ~clk_i;
	task wrap_up();
		$display("mismatches %0d of %0d compares", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Request held until ack is sampled; the next call adds the idle cycle
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		sel <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
		sel <= 1'h0;
	endtask
	task boot(input logic j, s, e, a, input logic [7:0] fc, input logic [15:0] pc);
		jmp <= j;
		psn <= s;
		acc <= e;
		ale <= a;
		reset_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		chk(lk.flash_control_reg, fc);
		chk(lk.start_pc, pc);
		chk(lk.boot_en, j);
		chk(lk.boot_vec, `SBV_DEFAULT);
	endtask
	// Counts busy cycles and done pulses over a window longer than one program
	task prog(input logic [7:0] fb, hi, lo, k1, k2, input logic mid, input int n_exp,
		input logic [15:0] pg);
		int n, d;
		n = 0;
		d = 0;
		wb(1'h1, 4'h4, fb);
		wb(1'h1, 4'h1, hi);
		wb(1'h1, 4'h1, lo);
		wb(1'h1, 4'h2, 8'h5A);
		wb(1'h1, 4'h0, k1);
		if (mid) wb(1'h1, 4'h2, 8'h11);
		wb(1'h1, 4'h0, k2);
		// No traffic while busy, as software with interrupts masked would behave
		repeat (20) begin
			@(posedge clk_i);
			n += (lk.busy === 1'h1);
			d += (done === 1'h1);
		end
		chk(16'(n), 16'(n_exp));
		chk(16'(d), 16'(n_exp != 0));
		chk(page, pg);
	endtask
	initial begin
		boot(1'h1, 1'h0, 1'h1, 1'h1, `FLASH_CONTROL_REG_HW, `PC_BOOT);
		boot(1'h1, 1'h0, 1'h1, 1'h0, `FLASH_CONTROL_REG_SW, `PC_USER);
		boot(1'h1, 1'h0, 1'h0, 1'h1, `FLASH_CONTROL_REG_SW, `PC_USER);
		boot(1'h0, 1'h1, 1'h1, 1'h1, `FLASH_CONTROL_REG_SW, `PC_BOOT);
		boot(1'h1, 1'h1, 1'h1, 1'h1, `FLASH_CONTROL_REG_SW, `PC_USER);
		wb(1'h0, 4'h4, 8'h00);
		chk(rd, `SBV_DEFAULT);
		wb(1'h0, 4'hF, 8'h00);
		chk(rd, 16'h0000);
		wb(1'h0, 4'h3, 8'h00);
		chk(rd, 16'h0002);
		wb(1'h0, 4'h0, 8'h00);
		chk(rd, `FLASH_CONTROL_REG_SW);
		wb(1'h0, 4'h1, 8'h00);
		chk(rd, 16'h0000);
		prog(8'h01, 8'h7F, 8'h85, `KEY_USER_A, `KEY_USER_B, 1'h0, 8, 16'h7F80);
		prog(8'h01, 8'hFF, 8'hC0, `KEY_XROW_A, `KEY_XROW_B, 1'h0, 8, 16'hFF80);
		prog(8'h01, 8'h01, 8'h00, `KEY_USER_A, `KEY_XROW_B, 1'h0, 0, 16'h0100);
		prog(8'h01, 8'h02, 8'h00, `KEY_USER_A, `KEY_USER_B, 1'h1, 0, 16'h0200);
		prog(8'h00, 8'h03, 8'h00, `KEY_USER_A, `KEY_USER_B, 1'h0, 0, 16'h0300);
		prog(8'h01, 8'h90, 8'h00, `KEY_XROW_A, `KEY_USER_B, 1'h0, 0, 16'h0300);
		prog(8'h01, 8'hF8, 8'h00, `KEY_USER_A, `KEY_XROW_B, 1'h0, 0, 16'h0300);
		wrap_up();
	end
endmodule
